/* File: core/pg_pkg.sv */
// package: constants for the suspend clock and power gating control block
package pg_pkg;
   // ********************************************************
   // register layout of common_clock_power_gating_config
   // ********************************************************
   localparam int unsigned      CFG_WIDTH       = 32;
   localparam logic [31:0]      CFG_RESET       = 32'h4880_0210;
   localparam int unsigned      MODE_MSB        = 15;
   localparam int unsigned      MODE_LSB        = 14;
   localparam int unsigned      CAL_SRC_SEL_BIT = 13;
   localparam int unsigned      LANE_B_EN_BIT   = 12;
   localparam int unsigned      CMN_B_EN_BIT    = 11;
   localparam int unsigned      GAON_EN_BIT     = 10;
   localparam int unsigned      PLL_HOLD_BIT    = 9;
   localparam int unsigned      CAL_GATE_DIS_BIT = 8;
   localparam int unsigned      LANE_A_EN_BIT   = 7;
   localparam int unsigned      CMN_A_EN_BIT    = 6;
   localparam int unsigned      DIG_EN_BIT      = 5;
   localparam int unsigned      DELAY_MSB       = 4;
   localparam int unsigned      DELAY_LSB       = 0;
   localparam int unsigned      DELAY_WIDTH     = 5;
   // bits that software can set; bit 13 never stores a one
   localparam logic [31:0]      CFG_WR_MASK     = 32'hFFFF_DFFF;

   // ********************************************************
   // power gate enable vector order
   // ********************************************************
   localparam int unsigned      PG_NUM          = 6;
   localparam int unsigned      PG_DIG          = 0;
   localparam int unsigned      PG_CMN_A        = 1;
   localparam int unsigned      PG_LANE_A       = 2;
   localparam int unsigned      PG_GAON         = 3;
   localparam int unsigned      PG_CMN_B        = 4;
   localparam int unsigned      PG_LANE_B       = 5;

   // ********************************************************
   // gating modes and power states
   // ********************************************************
   localparam logic [1:0]       MODE_FORCED     = 2'h0;
   localparam logic [1:0]       MODE_REQ_ONLY   = 2'h1;
   localparam logic [1:0]       MODE_GATE_ONLY  = 2'h2;
   localparam logic [1:0]       MODE_GATE_REQ   = 2'h3;
   localparam logic [2:0]       PS_GATE_LOW     = 3'h3;
   localparam int unsigned      REQ_NUM         = 4;
   localparam int unsigned      SYNC_WIDTH      = 8;
endpackage

/* File: core/pg_sync2.sv */
// two flip-flop level synchroniser for signals from outside the clock
`timescale 1ns/1ns
`default_nettype none
module pg_sync2 #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   // ********************************************************
   // state: first stage feeds only the second stage
   // ********************************************************
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] safe;
   } pg_sync_state_t;

   pg_sync_state_t st_ff;    // registered state
   pg_sync_state_t nxt_st;   // next state

   // shift the stages
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.meta = async_i;
      nxt_st.safe = st_ff.meta;
   end

   // constant reset, stages clear
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_o = st_ff.safe;
endmodule
`default_nettype wire

/* File: core/pg_susclk_ctrl.sv */
// suspend clock gating, clock request and power gating control
`timescale 1ns/1ns
`default_nettype none
//Function
// - mode 00: never gate, request high
// - mode 01: never gate, request follows need
// - mode 10: gate idle states 3-7, request high
// - mode 11: gate idle states 3-7, request follows
// - hold clock delay-field cycles after requests
// - calibration clock gated unless disable bit
// - pll hold keeps common B powered
// - lane B, common B, gaon enables
// - lane A, common A, digital enables
// - io manager override replaces software enables
// - calibration source select reads zero
module pg_susclk_ctrl #(
   parameter int unsigned REQ_NUM = pg_pkg::REQ_NUM
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_b_i,
   input  wire logic                       cfg_wr_en_i,
   input  wire logic [31:0]                cfg_wr_data_i,
   output logic      [31:0]                cfg_rd_data_o,
   input  wire logic [REQ_NUM-1:0]         susclk_req_i,
   input  wire logic [2:0]                 power_state_i,
   input  wire logic                       pll_number_one_en_i,
   input  wire logic                       io_manager_ovr_valid_i,
   input  wire logic [pg_pkg::PG_NUM-1:0]  io_manager_pg_en_i,
   output logic                            susclk_run_o,
   output logic                            clock_request_out_o,
   output logic                            calclk_gate_en_o,
   output logic      [pg_pkg::PG_NUM-1:0]  power_gate_en_o
);
   // ********************************************************
   // state of the block
   // ********************************************************
   typedef struct packed {
      logic [31:0]                       cfg;      // config register
      logic [pg_pkg::DELAY_WIDTH-1:0]    cnt;      // hold countdown
      logic                              run;      // clock enable out
      logic                              req_out;  // request out
      logic                              cal_gate; // cal gating allowed
      logic [pg_pkg::PG_NUM-1:0]         pg_en;    // domain enables
   } pg_ctrl_state_t;

   pg_ctrl_state_t                 st_ff;     // registered state
   pg_ctrl_state_t                 nxt_st;    // next state
   logic [pg_pkg::SYNC_WIDTH-1:0]  raw_in;    // pin level inputs
   logic [pg_pkg::SYNC_WIDTH-1:0]  sync_in;   // synchronised copies
   logic                           pll_s;     // pll one enabled
   logic                           ovr_s;     // override active
   logic [pg_pkg::PG_NUM-1:0]      ovr_en_s;  // override values
   logic                           need;      // any request present
   logic [1:0]                     mode;      // gating mode field
   logic                           in_ps;     // power state 3..7
   logic [pg_pkg::PG_NUM-1:0]      sw_en;     // software enables
   logic [pg_pkg::PG_NUM-1:0]      eff_en;    // chosen enables

   // ********************************************************
   // pin inputs cross in through two flops
   // ********************************************************
   assign raw_in = {io_manager_pg_en_i, io_manager_ovr_valid_i,
                    pll_number_one_en_i};

   pg_sync2 #(
      .WIDTH (pg_pkg::SYNC_WIDTH)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .async_i    (raw_in),
      .sync_o     (sync_in)
   );

   assign pll_s    = sync_in[0];
   assign ovr_s    = sync_in[1];
   assign ovr_en_s = sync_in[pg_pkg::SYNC_WIDTH-1:2];

   // ********************************************************
   // decode
   // ********************************************************
   assign need  = |susclk_req_i;
   assign mode  = st_ff.cfg[pg_pkg::MODE_MSB:pg_pkg::MODE_LSB];
   // states above two are the deep ones where gating may happen
   assign in_ps = (power_state_i >= pg_pkg::PS_GATE_LOW);

   // software view of the six domain enables
   always_comb begin
      sw_en                    = '0;
      sw_en[pg_pkg::PG_DIG]    = st_ff.cfg[pg_pkg::DIG_EN_BIT];
      sw_en[pg_pkg::PG_CMN_A]  = st_ff.cfg[pg_pkg::CMN_A_EN_BIT];
      sw_en[pg_pkg::PG_LANE_A] = st_ff.cfg[pg_pkg::LANE_A_EN_BIT];
      sw_en[pg_pkg::PG_GAON]   = st_ff.cfg[pg_pkg::GAON_EN_BIT];
      sw_en[pg_pkg::PG_CMN_B]  = st_ff.cfg[pg_pkg::CMN_B_EN_BIT];
      sw_en[pg_pkg::PG_LANE_B] = st_ff.cfg[pg_pkg::LANE_B_EN_BIT];
   end

   // override wins over software while the manager holds it
   assign eff_en = ovr_s ? ovr_en_s : sw_en;

   // ********************************************************
   // next state
   // ********************************************************
   always_comb begin
      nxt_st = st_ff;
      // register write; source select never stores a one
      if (cfg_wr_en_i) begin
         nxt_st.cfg = cfg_wr_data_i & pg_pkg::CFG_WR_MASK;
      end
      // countdown reloads while any request stands, so a request
      // arriving mid countdown cancels it and restarts in full
      if (need) begin
         nxt_st.cnt = st_ff.cfg[pg_pkg::DELAY_MSB:
                                pg_pkg::DELAY_LSB];
      end else if (st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
      // clock enable and request per mode
      case (mode)
         pg_pkg::MODE_FORCED: begin
            nxt_st.run     = 1'b1;
            nxt_st.req_out = 1'b1;
         end
         pg_pkg::MODE_REQ_ONLY: begin
            nxt_st.run     = 1'b1;
            nxt_st.req_out = need || (st_ff.cnt != '0);
         end
         pg_pkg::MODE_GATE_ONLY: begin
            nxt_st.run     = !in_ps || need || (st_ff.cnt != '0);
            nxt_st.req_out = 1'b1;
         end
         pg_pkg::MODE_GATE_REQ: begin
            nxt_st.run     = !in_ps || need || (st_ff.cnt != '0);
            nxt_st.req_out = need || (st_ff.cnt != '0);
         end
         default: begin
            nxt_st.run     = 1'b1;
            nxt_st.req_out = 1'b1;
         end
      endcase
      // calibration clock may be gated only while disable is clear
      nxt_st.cal_gate = !st_ff.cfg[pg_pkg::CAL_GATE_DIS_BIT];
      // common B must stay powered while pll one runs, if held
      nxt_st.pg_en = eff_en;
      if (st_ff.cfg[pg_pkg::PLL_HOLD_BIT] && pll_s) begin
         nxt_st.pg_en[pg_pkg::PG_CMN_B] = 1'b0;
      end
   end

   // ********************************************************
   // registers: reset leaves the clock running and request high
   // ********************************************************
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff          <= '0;
         st_ff.cfg      <= pg_pkg::CFG_RESET;
         st_ff.run      <= 1'b1;
         st_ff.req_out  <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cfg_rd_data_o       = st_ff.cfg;
   assign susclk_run_o        = st_ff.run;
   assign clock_request_out_o = st_ff.req_out;
   assign calclk_gate_en_o    = st_ff.cal_gate;
   assign power_gate_en_o     = st_ff.pg_en;

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   // all requests fall after standing for a cycle
   sequence s_req_drop;
      need ##1 !need;
   endsequence

   // deep state with no request
   sequence s_idle_deep;
      mode[1] && in_ps && !need;
   endsequence

   AST_MODE_FORCED: assert property (
      (mode == pg_pkg::MODE_FORCED) |=> (susclk_run_o && clock_request_out_o))
      else $error("forced mode lost clock or request");

   AST_MODE_REQ_ONLY: assert property (
      (mode == pg_pkg::MODE_REQ_ONLY) && need |=> (susclk_run_o
         && clock_request_out_o))
      else $error("request-only mode wrong");

   AST_MODE_GATE_ONLY: assert property (
      (mode == pg_pkg::MODE_GATE_ONLY) |=> clock_request_out_o)
      else $error("gate-only mode dropped request");

   AST_MODE_GATE_REQ: assert property (
      s_idle_deep and (st_ff.cnt == '0) |=> !susclk_run_o)
      else $error("idle deep state clock not gated");

   AST_DELAY_LOAD: assert property (
      s_req_drop |-> (st_ff.cnt
         == $past(st_ff.cfg[pg_pkg::DELAY_MSB:pg_pkg::DELAY_LSB], 1)))
      else $error("hold count not loaded from delay field");

   AST_DELAY_RUN: assert property (
      s_idle_deep and (st_ff.cnt != '0) |=> susclk_run_o
         && (st_ff.cnt == $past(st_ff.cnt) - 5'h01))
      else $error("clock gated during hold countdown");

   // a request in a gating mode keeps the clock and reloads the full
   // delay, so the next drop counts down from the top, not the middle
   AST_RESTART: assert property (
      mode[1] && need |=> susclk_run_o
         && (st_ff.cnt
            == $past(st_ff.cfg[pg_pkg::DELAY_MSB:pg_pkg::DELAY_LSB])))
      else $error("request did not restart the hold countdown");

   // request modes let the request fall once the hold has run out
   AST_REQ_DROP: assert property (
      mode[0] && !need && (st_ff.cnt == '0) |=> !clock_request_out_o)
      else $error("request stayed high with nothing needing the clock");

   AST_CAL_GATE: assert property (
      1'b1 |=> (calclk_gate_en_o
         == !$past(st_ff.cfg[pg_pkg::CAL_GATE_DIS_BIT])))
      else $error("calibration gating wrong");

   AST_PLL_HOLD: assert property (
      st_ff.cfg[pg_pkg::PLL_HOLD_BIT] && pll_s
         |=> !power_gate_en_o[pg_pkg::PG_CMN_B])
      else $error("common B gated while pll runs");

   AST_OVERRIDE: assert property (
      ovr_s |=> (power_gate_en_o[3:0] == $past(ovr_en_s[3:0]))
         && (power_gate_en_o[5] == $past(ovr_en_s[5])))
      else $error("override values not used");

   AST_SW_EN: assert property (
      !ovr_s |=> (power_gate_en_o[pg_pkg::PG_LANE_B]
            == $past(st_ff.cfg[pg_pkg::LANE_B_EN_BIT]))
         && (power_gate_en_o[pg_pkg::PG_GAON]
            == $past(st_ff.cfg[pg_pkg::GAON_EN_BIT]))
         && (power_gate_en_o[pg_pkg::PG_LANE_A]
            == $past(st_ff.cfg[pg_pkg::LANE_A_EN_BIT]))
         && (power_gate_en_o[pg_pkg::PG_CMN_A]
            == $past(st_ff.cfg[pg_pkg::CMN_A_EN_BIT]))
         && (power_gate_en_o[pg_pkg::PG_DIG]
            == $past(st_ff.cfg[pg_pkg::DIG_EN_BIT])))
      else $error("software enables not used");

   AST_SRC_SEL_ZERO: assert property (
      cfg_rd_data_o[pg_pkg::CAL_SRC_SEL_BIT] == 1'b0)
      else $error("source select read back one");
endmodule
`default_nettype wire

/* File: verif/pg_iom_model.sv */
// far side model: io manager override pins and pll one enable
`timescale 1ns/1ns
`default_nettype none
module pg_io_manager_model (
   input  wire logic       core_clk_i,
   input  wire logic       ovr_cmd_i,
   input  wire logic [5:0] pg_cmd_i,
   input  wire logic       pll_cmd_i,
   output logic            ovr_valid_o,
   output logic      [5:0] pg_en_o,
   output logic            pll_en_o
);
   // ****************************************
   // pin drive
   // ****************************************
   // pins move away from the design's sampling edge; one process
   // drives every pin, the bench holds the design's synchroniser in reset
   // until the sixth falling edge, long after the first has set them
   always @(negedge core_clk_i) begin
      ovr_valid_o <= ovr_cmd_i;
      // released enables show the inverse, so a stale value that the
      // design wrongly kept using would be caught at once
      pg_en_o     <= ovr_cmd_i ? pg_cmd_i : ~pg_cmd_i;
      pll_en_o    <= pll_cmd_i;
   end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the suspend clock and power gating control
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic        clk = 1'b0;     // 25 MHz core clock
   logic        rst_b = 1'b0;   // active low reset
   logic        wr_en = 1'b0;   // config write strobe
   logic [31:0] wr_data = 32'h0000_0000;
   logic [3:0]  req = 4'h0;     // suspend clock requests
   logic [2:0]  ps = 3'h0;      // power state
   logic        ovr_cmd = 1'b0; // override command to far side
   logic [5:0]  pg_cmd = 6'h00;
   logic        pll_cmd = 1'b0;
   logic        ovr_valid, pll_en, run, clk_req, cal_gate;
   logic [5:0]  mgr_pg, pg_en;
   logic [31:0] rd_data;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          cycles = 0;
   always #20 clk = ~clk;
   pg_susclk_ctrl #(.REQ_NUM(4)) dut (
      .core_clk_i(clk), .rst_b_i(rst_b), .cfg_wr_en_i(wr_en),
      .cfg_wr_data_i(wr_data), .cfg_rd_data_o(rd_data),
      .susclk_req_i(req), .power_state_i(ps),
      .pll_number_one_en_i(pll_en), .io_manager_ovr_valid_i(ovr_valid),
      .io_manager_pg_en_i(mgr_pg), .susclk_run_o(run),
      .clock_request_out_o(clk_req), .calclk_gate_en_o(cal_gate),
      .power_gate_en_o(pg_en));
   pg_io_manager_model u_far (
      .core_clk_i(clk), .ovr_cmd_i(ovr_cmd), .pg_cmd_i(pg_cmd),
      .pll_cmd_i(pll_cmd), .ovr_valid_o(ovr_valid), .pg_en_o(mgr_pg),
      .pll_en_o(pll_en));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one write, returns once outputs reflect it
   task automatic wr(input logic [31:0] d);
      @(negedge clk);
      wr_en <= 1'b1;
      wr_data <= d;
      @(negedge clk);
      wr_en <= 1'b0;
      cyc(2);
   endtask
   // counts cycles of run and request after the last request drops;
   // 12 means the output never fell
   task automatic meas(input logic [31:0] er, eq, input bit rs);
      int nr;
      int nq;
      nr = 0;
      nq = 0;
      req <= 4'h2;
      cyc(2);
      req <= 4'h0;
      if (rs) begin
         cyc(2);
         req <= 4'h8; // late request mid countdown
         cyc(1);
         req <= 4'h0;
      end
      for (int i = 0; i < 12; i++) begin
         @(negedge clk);
         nr += int'(run === 1'b1);
         nq += int'(clk_req === 1'b1);
      end
      chk("run cycles", er, nr);
      chk("request cycles", eq, nq);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      chk("cfg reset", 32'h4880_0210, rd_data);
      chk("run reset", 32'h1, run);
      chk("request reset", 32'h1, clk_req);
      chk("pg reset", 32'h0, pg_en);
      chk("cal reset", 32'h1, cal_gate);
      $display("test reset done");
   endtask
   task automatic t_srcsel;
      wr(32'hFFFF_FFFF);
      chk("cfg ones", 32'hFFFF_DFFF, rd_data);
      $display("test source select done");
   endtask
   // delay field 3: gating modes keep the clock for exactly 3 cycles
   // after the design first sees every request low
   task automatic t_modes;
      ps <= 3'h3;
      wr(32'h4880_0203);
      meas(12, 12, 0);
      wr(32'h4880_4203);
      meas(12, 3, 0);
      wr(32'h4880_8203);
      meas(3, 12, 0);
      wr(32'h4880_C203);
      meas(3, 3, 0);
      ps <= 3'h2; // below the gating states
      wr(32'h4880_8203);
      meas(12, 12, 0);
      ps <= 3'h7;
      wr(32'h4880_C203);
      meas(3, 3, 1);
      $display("test modes done");
   endtask
   task automatic t_enables;
      wr(32'h4880_1FE0);
      chk("pg all", 32'h3F, pg_en);
      chk("cal disabled", 32'h0, cal_gate);
      pll_cmd <= 1'b1;
      cyc(5);
      chk("pg pll hold", 32'h2F, pg_en);
      wr(32'h4880_1CE0);
      chk("pg no hold", 32'h3F, pg_en);
      chk("cal enabled", 32'h1, cal_gate);
      wr(32'h4880_1040);
      chk("pg pick", 32'h22, pg_en);
      pll_cmd <= 1'b0;
      $display("test enables done");
   endtask
   task automatic t_override;
      wr(32'h4880_1CE0);
      pg_cmd <= 6'h1B;
      ovr_cmd <= 1'b1;
      cyc(5);
      chk("pg override", 32'h1B, pg_en);
      ovr_cmd <= 1'b0;
      cyc(5);
      chk("pg software", 32'h3F, pg_en);
      $display("test override done");
   endtask
   // ****************************************
   // run control
   // ****************************************
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // hang guard, far above the roughly 150 cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      cyc(6);
      rst_b <= 1'b1;
      cyc(1);
      t_reset();
      t_srcsel();
      t_modes();
      t_enables();
      t_override();
      complete_run();
   end
endmodule
`default_nettype wire
